// File: rtl/twm_ctrl.v
// Two-wire bus controller-send engine with control, state and byte registers
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.vh"
// Summary of operation
// - Four modes exist; software picks which ones it uses. Only controller send is built here.
// - Transfer stalls with clock held low while the flag is set, except after lost arbitration, when the clock is released.
// - Controller mode needs START; address direction bit picks send or receive.
// - START is generated only once the bus is seen free.
// - After START the flag is set and code 0x08 shown.
// - Writing one to the flag clears it and continues the transfer.
// - After address and acknowledge bit, flag set with 0x18, 0x20 or 0x38.
// - Byte register write while flag low is dropped and sets write collision.
// - After each data byte and acknowledge bit the flag is set.
// - Repeated START requested with start 1, stop 0; code 0x10 after it.
// - Repeated START keeps the bus; any target and direction may follow.
// - Read bit high, write low, acknowledge low, bytes are eight bits.
// - Data byte acknowledged gives 0x28, not acknowledged gives 0x30.
// - Lost arbitration gives 0x38, releases bus, restarts when free if requested.
// - Stop request bit clears itself after STOP is sent.
// - Stop plus start sends STOP then START and clears stop request.
module twm_ctrl (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire [1:0] reg_sel,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output reg [1:0] ctl_mode_r,
  input wire scl_in,
  output reg scl_out_r,
  output reg scl_oe_r,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_STA = 4'h1;
  localparam [3:0] S_HOLD = 4'h2;
  localparam [3:0] S_BLO = 4'h3;
  localparam [3:0] S_BHI = 4'h4;
  localparam [3:0] S_ALO = 4'h5;
  localparam [3:0] S_AHI = 4'h6;
  localparam [3:0] S_STP1 = 4'h7;
  localparam [3:0] S_STP2 = 4'h8;
  localparam [3:0] S_STP3 = 4'h9;
  localparam [3:0] S_RS1 = 4'ha;
  localparam [3:0] S_RS2 = 4'hb;
  localparam integer HALF_I = `TWM_HALF_CYC;
  localparam [11:0] HALF = HALF_I[11:0];

  reg [1:0] scl_sync_r;
  reg [1:0] sda_sync_r;
  reg scl_d_r;
  reg sda_d_r;
  reg busy_r;
  reg [7:0] ctrl_r;
  reg [4:0] code_r;
  reg [1:0] presc_r;
  reg [7:0] byte_r;
  reg [7:0] shift_r;
  reg [2:0] bit_r;
  reg [3:0] state_r;
  reg [11:0] cnt_r;
  reg addr_ph_r;
  reg rep_r;

  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];
  wire flag = ctrl_r[`TWM_B_INT];
  wire en = ctrl_r[`TWM_B_EN];
  wire ctrl_wr = reg_wr && (reg_sel == `TWM_SEL_CTRL);
  wire data_wr = reg_wr && (reg_sel == `TWM_SEL_DATA);
  wire half_done = (cnt_r == HALF - 12'h001);
  wire hi_done = half_done && scl_s;

  reg [3:0] state_nxt;
  reg [11:0] cnt_nxt;
  reg set_flag;
  reg [4:0] set_code;
  reg clr_sto;
  reg scl_drv;
  reg sda_drv;

  // Bus engine next state
  always @* begin
    state_nxt = state_r;
    cnt_nxt = half_done ? 12'h000 : cnt_r + 12'h001;
    set_flag = 1'b0;
    set_code = code_r;
    clr_sto = 1'b0;
    scl_drv = 1'b0;
    sda_drv = 1'b0;
    case (state_r)
      S_IDLE: begin
        cnt_nxt = 12'h000;
        if (en && ctrl_r[`TWM_B_STA] && !flag && !busy_r) begin
          state_nxt = S_STA;
        end
      end
      S_STA: begin
        sda_drv = 1'b1;
        if (half_done) begin
          state_nxt = S_HOLD;
          set_flag = 1'b1;
          set_code = rep_r ? `TWM_ST_RSTART : `TWM_ST_START;
        end
      end
      S_HOLD: begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        cnt_nxt = 12'h000;
        if (!flag) begin
          if (ctrl_r[`TWM_B_STO]) begin
            state_nxt = S_STP1;
          end else if (ctrl_r[`TWM_B_STA]) begin
            state_nxt = S_RS1;
          end else begin
            state_nxt = S_BLO;
          end
        end
      end
      S_BLO: begin
        scl_drv = 1'b1;
        sda_drv = ~shift_r[7];
        if (half_done) begin
          state_nxt = S_BHI;
        end
      end
      S_BHI: begin
        sda_drv = ~shift_r[7];
        if (!scl_s) begin
          cnt_nxt = 12'h000;
        end else if (hi_done) begin
          if (shift_r[7] && !sda_s) begin
            state_nxt = S_IDLE;
            set_flag = 1'b1;
            set_code = `TWM_ST_ARB;
          end else if (bit_r == 3'h0) begin
            state_nxt = S_ALO;
          end else begin
            state_nxt = S_BLO;
          end
        end
      end
      S_ALO: begin
        scl_drv = 1'b1;
        if (half_done) begin
          state_nxt = S_AHI;
        end
      end
      S_AHI: begin
        if (!scl_s) begin
          cnt_nxt = 12'h000;
        end else if (hi_done) begin
          state_nxt = S_HOLD;
          set_flag = 1'b1;
          if (addr_ph_r) begin
            set_code = sda_s ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
          end else begin
            set_code = sda_s ? `TWM_ST_D_NACK : `TWM_ST_D_ACK;
          end
        end
      end
      S_STP1: begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        if (half_done) begin
          state_nxt = S_STP2;
        end
      end
      S_STP2: begin
        sda_drv = 1'b1;
        if (!scl_s) begin
          cnt_nxt = 12'h000;
        end else if (hi_done) begin
          state_nxt = S_STP3;
        end
      end
      S_STP3: begin
        if (half_done) begin
          state_nxt = S_IDLE;
          clr_sto = 1'b1;
          set_code = `TWM_ST_IDLE;
        end
      end
      S_RS1: begin
        scl_drv = 1'b1;
        if (half_done) begin
          state_nxt = S_RS2;
        end
      end
      S_RS2: begin
        if (!scl_s) begin
          cnt_nxt = 12'h000;
        end else if (hi_done) begin
          state_nxt = S_STA;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    if (!en) begin
      state_nxt = S_IDLE;
      cnt_nxt = 12'h000;
      scl_drv = 1'b0;
      sda_drv = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_r <= 1'b0;
      ctrl_r <= `TWM_CTRL_RST;
      code_r <= `TWM_ST_IDLE;
      presc_r <= 2'h0;
      byte_r <= `TWM_DATA_RST;
      shift_r <= 8'h00;
      bit_r <= 3'h7;
      state_r <= S_IDLE;
      cnt_r <= 12'h000;
      addr_ph_r <= 1'b0;
      rep_r <= 1'b0;
      ctl_mode_r <= 2'h0;
      reg_rdata_r <= 8'h00;
      scl_out_r <= 1'b0;
      sda_out_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (ce) begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      // Bus busy from START and STOP seen on the lines
      if (scl_s && scl_d_r && sda_d_r && !sda_s) begin
        busy_r <= 1'b1;
      end else if (scl_s && scl_d_r && !sda_d_r && sda_s) begin
        busy_r <= 1'b0;
      end
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      scl_oe_r <= scl_drv;
      sda_oe_r <= sda_drv;
      scl_out_r <= 1'b0;
      sda_out_r <= 1'b0;
      code_r <= set_code;
      if (state_r == S_HOLD && !flag && en) begin
        shift_r <= byte_r;
        bit_r <= 3'h7;
        rep_r <= ctrl_r[`TWM_B_STA] && !ctrl_r[`TWM_B_STO];
      end else if (state_r == S_BHI && hi_done) begin
        shift_r <= {shift_r[6:0], 1'b0};
        bit_r <= bit_r - 3'h1;
      end
      if (state_r == S_STA && half_done) begin
        addr_ph_r <= 1'b1;
        ctl_mode_r <= 2'h0;
      end else if (state_r == S_AHI && hi_done) begin
        addr_ph_r <= 1'b0;
        if (addr_ph_r) begin
          ctl_mode_r <= byte_r[0] ? 2'h2 : 2'h1;
        end
      end
      if (state_nxt == S_IDLE && state_r != S_IDLE) begin
        rep_r <= 1'b0;
        ctl_mode_r <= 2'h0;
      end
      // Control register: writing one to the flag clears it, hardware set wins
      if (ctrl_wr) begin
        ctrl_r[`TWM_B_ACKEN] <= reg_wdata[`TWM_B_ACKEN];
        ctrl_r[`TWM_B_STA] <= reg_wdata[`TWM_B_STA];
        ctrl_r[`TWM_B_STO] <= reg_wdata[`TWM_B_STO];
        ctrl_r[`TWM_B_EN] <= reg_wdata[`TWM_B_EN];
        ctrl_r[`TWM_B_IE] <= reg_wdata[`TWM_B_IE];
      end
      if (clr_sto) begin
        ctrl_r[`TWM_B_STO] <= 1'b0;
      end
      if (set_flag) begin
        ctrl_r[`TWM_B_INT] <= 1'b1;
      end else if (ctrl_wr && reg_wdata[`TWM_B_INT]) begin
        ctrl_r[`TWM_B_INT] <= 1'b0;
      end
      if (data_wr) begin
        if (flag) begin
          byte_r <= reg_wdata;
          ctrl_r[`TWM_B_WC] <= 1'b0;
        end else begin
          ctrl_r[`TWM_B_WC] <= 1'b1;
        end
      end
      if (reg_wr && reg_sel == `TWM_SEL_STAT) begin
        presc_r <= reg_wdata[1:0];
      end
      if (reg_rd) begin
        case (reg_sel)
          `TWM_SEL_CTRL: reg_rdata_r <= ctrl_r;
          `TWM_SEL_STAT: reg_rdata_r <= {code_r, 1'b0, presc_r};
          `TWM_SEL_DATA: reg_rdata_r <= byte_r;
          default: reg_rdata_r <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/twm_map.vh
// Register selects, field positions, status codes and bus timing for the two-wire controller
`ifndef TWM_MAP_VH
`define TWM_MAP_VH
`define TWM_SEL_CTRL 2'h0
`define TWM_SEL_STAT 2'h1
`define TWM_SEL_DATA 2'h2
`define TWM_B_INT 7
`define TWM_B_ACKEN 6
`define TWM_B_STA 5
`define TWM_B_STO 4
`define TWM_B_WC 3
`define TWM_B_EN 2
`define TWM_B_IE 0
`define TWM_CTRL_RST 8'h00
`define TWM_STAT_RST 8'hf8
`define TWM_DATA_RST 8'hff
`define TWM_ST_START 5'h01
`define TWM_ST_RSTART 5'h02
`define TWM_ST_AW_ACK 5'h03
`define TWM_ST_AW_NACK 5'h04
`define TWM_ST_D_ACK 5'h05
`define TWM_ST_D_NACK 5'h06
`define TWM_ST_ARB 5'h07
`define TWM_ST_IDLE 5'h1f
`define TWM_CLK_NS 25
`define TWM_HALF_NS 5000
`define TWM_HALF_CYC ((`TWM_HALF_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS)
`endif

// File: verification/twm_slave.sv
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module twm_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic sda_pull,
  output logic [7:0] got
);
  int n = 0;
  initial sda_pull = 1'b0;
  initial got = 8'h00;
  always @(negedge sda) if (scl) n = 0;
  always @(posedge scl) begin
    if (n < 8) got = {got[6:0], sda};
    n = n + 1;
  end
  always @(negedge scl) begin
    if (n == 8) sda_pull <= !nack;
    else if (n == 9) begin
      sda_pull <= 1'b0;
      n = 0;
    end
  end
endmodule
`default_nettype wire

// File: verification/twm_ctrl_chk.sv
// Assertion checker bound to the two-wire controller-send engine
`timescale 1ns/1ps
`default_nettype none
module twm_ctrl_chk (
  input wire clk,
  input wire rst_b,
  input wire [1:0] reg_sel,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r,
  input wire scl_in,
  input wire scl_out_r,
  input wire scl_oe_r,
  input wire sda_in,
  input wire sda_out_r,
  input wire sda_oe_r
);
  logic [8:0] lo_cnt;
  logic held, clr_seen, en_r;
  wire ctl_wr = reg_wr && reg_sel == 2'h0;
  wire clr_wr = ctl_wr && (reg_wdata[7] || !reg_wdata[2]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A long clock-low stretch with no clearing write is a flag hold
  always @(posedge clk) begin
    if (!rst_b) begin
      {lo_cnt, held, clr_seen, en_r} <= 12'h000;
    end else begin
      lo_cnt <= scl_oe_r ? lo_cnt + {8'h00, lo_cnt != 9'h1ff} : 9'h000;
      clr_seen <= scl_oe_r && (clr_seen || clr_wr);
      en_r <= ctl_wr ? reg_wdata[2] : en_r;
      held <= !clr_wr && (held || (lo_cnt == 9'h0fa && !clr_seen));
    end
  end
  a_lines_low: assert property (!scl_out_r && !sda_out_r) else $error("output not low");
  a_rsvd_zero: assert property (reg_rd && reg_sel == 2'h0 |=> !reg_rdata_r[1]) else $error("bit1 set");
  a_read_hold: assert property (!reg_rd |=> $stable(reg_rdata_r)) else $error("read data moved");
  a_enable_off: assert property (ctl_wr && !reg_wdata[2] |-> ##[1:4] !scl_oe_r && !sda_oe_r)
    else $error("lines kept");
  a_start_free: assert property ($rose(sda_oe_r) && !scl_oe_r |-> $past(scl_in) && $past(sda_in))
    else $error("start on busy bus");
  a_flag_hold: assert property (held |-> scl_oe_r) else $error("clock released in hold");
  a_hold_resume: assert property (held && clr_wr |-> ##[1:450] !scl_oe_r) else $error("no resume");
  a_stop_shape: assert property ($fell(sda_oe_r) && !scl_oe_r && en_r |-> !$past(scl_oe_r) && scl_in)
    else $error("bad stop");
endmodule
bind twm_ctrl twm_ctrl_chk chk_i (.clk(clk), .rst_b(rst_b), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .scl_in(scl_in), .scl_out_r(scl_out_r),
  .scl_oe_r(scl_oe_r), .sda_in(sda_in), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r));
`default_nettype wire

// File: verification/twm_ctrl_tb.sv
// Self-checking bench for the two-wire controller-send engine
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.vh"
module twm_ctrl_tb;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, nack = 1'b0, jam = 1'b0, ce = 1'b1;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] reg_wdata = 8'h00, v;
  logic [7:0] q[$];
  logic [7:0] rv[4] = '{`TWM_CTRL_RST, `TWM_STAT_RST, `TWM_DATA_RST, 8'h00};
  wire [7:0] rdata, got;
  wire [1:0] mode;
  wire scl_oe, sda_oe, sl_pull;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || sl_pull || jam);
  int error_cnt = 0, tests_run = 0;
  always #12.5 clk = !clk;
  twm_ctrl uut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .ctl_mode_r(mode), .scl_in(scl), .scl_out_r(),
    .scl_oe_r(scl_oe), .sda_in(sda), .sda_out_r(), .sda_oe_r(sda_oe));
  twm_slave sl (.scl(scl), .sda(sda), .nack(nack), .sda_pull(sl_pull), .got(got));
  task stop_test();
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk) #2;
    {reg_sel, reg_wdata, reg_wr} = {s, d, 1'b1};
    @(posedge clk) #2;
    reg_wr = 1'b0;
  endtask
  task rd(input logic [1:0] s);
    @(posedge clk) #2;
    {reg_sel, reg_rd} = {s, 1'b1};
    @(posedge clk) #2;
    reg_rd = 1'b0;
    v = rdata;
  endtask
  task wt(input int b, input logic e);
    for (int i = 0; i < 6000; i++) begin
      rd(2'h0);
      if (v[b] === e) return;
    end
    chk("control wait", {7'h00, v[b]}, {7'h00, e});
    stop_test();
  endtask
  task step(input logic [7:0] c, input logic [7:0] e);
    wr(2'h0, c);
    wt(7, 1'b1);
    rd(2'h1);
    chk("state", v & 8'hf8, e);
  endtask
  task snd(input logic [7:0] b, input logic adr, input logic nk);
    nack = nk;
    q.push_back(b);
    wr(2'h2, b);
    step(8'h84, adr ? (nk ? 8'h20 : 8'h18) : (nk ? 8'h30 : 8'h28));
    chk("sent byte", got, q.pop_front());
  endtask
  initial begin
    void'($urandom(32'h8959));
    repeat (20) @(posedge clk);
    #2 rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i));
      chk("reset value", v, rv[i]);
    end
    wr(2'h2, 8'h5a);
    rd(2'h2);
    chk("byte reg", v, `TWM_DATA_RST);
    rd(2'h0);
    chk("collision", v, 8'h08);
    // A write taken while the clock enable is low must leave the register untouched
    ce = 1'b0;
    wr(2'h0, 8'h41);
    ce = 1'b1;
    rd(2'h0);
    chk("frozen control", v, 8'h08);
    wr(2'h0, 8'h41);
    rd(2'h0);
    chk("control bits", v, 8'h49);
    wr(2'h1, 8'($urandom));
    rd(2'h1);
    chk("prescaler", v, 8'hf8 | (reg_wdata & 8'h03));
    wr(2'h1, 8'h00);
    $display("register test done");
    step(8'ha4, 8'h08);
    snd(8'ha0, 1'b1, 1'b0);
    rd(2'h0);
    chk("collision", v & 8'h08, 8'h00);
    chk("mode", {6'h00, mode}, 8'h01);
    for (int k = 0; k < 3; k++)
      snd(8'($urandom), 1'b0, k == 1);
    $display("send test done");
    step(8'ha4, 8'h10);
    snd(8'ha3, 1'b1, 1'b0);
    chk("mode", {6'h00, mode}, 8'h02);
    step(8'hb4, 8'h08);
    rd(2'h0);
    chk("stop request", v & 8'h10, 8'h00);
    snd(8'ha0, 1'b1, 1'b1);
    $display("restart test done");
    repeat (300) @(posedge clk);
    wr(2'h0, 8'h94);
    wt(4, 1'b0);
    rd(2'h1);
    chk("state idle", v, 8'hf8);
    rd(2'h0);
    chk("control idle", v, 8'h04);
    $display("stop test done");
    step(8'ha4, 8'h08);
    jam = 1'b1;
    wr(2'h2, 8'hff);
    step(8'h84, 8'h38);
    chk("clock oe", {7'h00, scl_oe}, 8'h00);
    jam = 1'b0;
    wr(2'h0, 8'h80);
    $display("arbitration test done");
    stop_test();
  end
endmodule
`default_nettype wire
